/* scgc_regs.vh */
// Register offsets, field positions, reset values and timing constants of the sub-clock gating control
`ifndef SCGC_REGS_VH
`define SCGC_REGS_VH
// Wishbone word offsets (byte addresses)
`define SCGC_ADDR_SYS_CTRL 8'hF0
`define SCGC_ADDR_SUBCLK 8'hF8
`define SCGC_ADDR_STATUS 8'hFC
// System control field layout
`define SCGC_DIV_MSB 2
`define SCGC_DIV_LSB 0
`define SCGC_SLEEP_BIT 3
`define SCGC_DIV_RESET 3'h7
`define SCGC_DIV_ONE 3'h0
// Sub-clock control: two bits per domain, enable low, demand high
`define SCGC_NUM_DOM 12
`define SCGC_PAIR_RESET 2'h1
`define SCGC_SUBCLK_RESET 24'h555555
// Domain indices
`define SCGC_D_RFREF 0
`define SCGC_D_CORBUS 1
`define SCGC_D_CORCORE 2
`define SCGC_D_SER1 3
`define SCGC_D_SER2 4
`define SCGC_D_TIMER 5
`define SCGC_D_SMST 6
`define SCGC_D_SSLV 7
`define SCGC_D_DEBUG 8
`define SCGC_D_MEMC 9
`define SCGC_D_CPU 10
`define SCGC_D_GPIO 11
// Slow enable deletion factor
`define SCGC_SLOW_FACTOR 1024
`define SCGC_SLOW_MAX 10'h3FF
`endif

/* scgc_gate.v */
// Glitch-free clock gate with a latch-free negative edge enable register
`timescale 1ns/1ps
module scgc_gate (
   input wire clk_in,
   input wire reset_n,
   input wire enable,
   output wire clk_out
);
   // Enable sampled on the falling edge so it only changes while clk_in is low
   reg enable_low;

   // ==========================================
   // Falling edge capture keeps both phases whole
   always @(negedge clk_in or negedge reset_n) begin
      if (!reset_n) begin
         enable_low <= 1'b0;
      end else begin
         enable_low <= enable;
      end
   end

   // AND gate is safe: enable_low only moves while the clock is low
   assign clk_out = clk_in & enable_low;
endmodule

/* scgc_top.v */
// Sub-clock gating control: source select, sleep, divider, slow enable and gated sub-clocks
// Overview of operation
// - RF reference clock divided by 1 to 8
// - Correlator core clock pulse-deleted by same factor
// - Source select low external, high internal
// - Sleep stops clock; wake, reset, alarm restart
// - Internal oscillator disabled on sleep entry
// - Sleep forces internal source selection
// - External power enable follows sleep state
// - Correlator bus clock is gated main clock
// - Separate gated clocks for each peripheral
// - Slow enable deletes reference pulses by 1024
// - All sub-clock gating is glitch free
// - Each domain enable bit switches its clock
// - Both bits set: clock follows demand
// - Cleared correlator enable stops all correlator clocks
// - Processor clock runs until memory access ends
// - Pending interrupt clears processor demand enable
// - Pair codes: off, always on, demand; reset 01
// - Divide field 111 is eight, 000 one
`timescale 1ns/1ps
`include "scgc_regs.vh"
module scgc_top #(
   parameter DIV_W = 3,
   parameter SLOW_W = 10
) (
   input wire ref_clk,
   input wire reset_n,
   // Clock sources
   input wire ext_clock,
   input wire osc_clock,
   input wire clock_source_select,
   // Wake-up events
   input wire ext_wakeup,
   input wire rtc_wakeup,
   // Demand requests, synchronous to the main clock
   input wire [11:0] demand_request,
   input wire memory_busy,
   input wire irq_pending,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output wire wb_ack_o,
   // Clock control outputs
   output wire osc_enable,
   output wire main_clock_select,
   output wire main_clock_run,
   output reg external_power_enable,
   output wire rf_reference_clock,
   output reg correlator_core_enable,
   output wire correlator_core_clock,
   output reg slow_enable,
   output wire [11:0] subclock
);
   // ==========================================
   // Registers and state
   reg [DIV_W-1:0] divide_field;          // Division setting, 111 = div 8
   reg go_sleep;                          // Sleep request from software
   reg [23:0] subclock_control_register;  // Enable/demand pairs
   reg ack;                               // Single-cycle bus answer
   reg [2:0] wake_sync;                   // Pin wake-up synchroniser
   reg [2:0] src_sync;                    // Source select synchroniser
   reg src_sel;                           // Filtered source select
   reg [DIV_W-1:0] div_count;             // Divider phase counter
   reg rf_ref;                            // Divided reference level
   reg [SLOW_W-1:0] slow_count;           // Reference pulse counter
   reg [11:0] gate_en;                    // Requested run per domain
   reg [11:0] next_gate_en;
   reg cpu_hold;                          // Processor clock kept for access
   integer i;                             // Byte lane index of the register write
   integer j;                             // Domain index of the run decision

   // Decodes one pair into a run request
   function pair_run;
      input [1:0] pair;
      input dmd;
      begin
         // Enable has priority, demand only matters when both set
         pair_run = pair[0] & (~pair[1] | dmd);
      end
   endfunction

   // Terminal count of the divider, 111 means 8 phases
   function [DIV_W-1:0] div_last;
      input [DIV_W-1:0] field;
      begin
         div_last = field;
      end
   endfunction

   wire bus_req = wb_cyc_i & wb_stb_i;
   // Write lands at the edge where the master sees ack high, never earlier
   wire wr = bus_req & wb_we_i & ack;
   wire wakeup = (wake_sync[2] & wake_sync[1]) | rtc_wakeup;

   // ==========================================
   // Bus slave: one wait state, ack dropped in the cycle after
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack <= 1'b0;
      end else begin
         ack <= bus_req & ~ack;
      end
   end
   assign wb_ack_o = ack;

   // Read data registered with the request; unmapped offsets read zero
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_dat_o <= 32'h0;
      end else if (bus_req & ~ack) begin
         case (wb_adr_i)
            `SCGC_ADDR_SYS_CTRL: begin
               wb_dat_o <= {28'h0, go_sleep, divide_field};
            end
            `SCGC_ADDR_SUBCLK: begin
               wb_dat_o <= {8'h0, subclock_control_register};
            end
            `SCGC_ADDR_STATUS: begin
               wb_dat_o <= {19'h0, src_sel, gate_en};
            end
            default: begin
               wb_dat_o <= 32'h0;
            end
         endcase
      end
   end

   // ==========================================
   // System control: divide field and sleep request
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         divide_field <= `SCGC_DIV_RESET;
         go_sleep <= 1'b0;
      end else begin
         if (wr && wb_adr_i == `SCGC_ADDR_SYS_CTRL && wb_sel_i[0]) begin
            divide_field <= wb_dat_i[`SCGC_DIV_MSB:`SCGC_DIV_LSB];
         end
         // Wake-up wins over a sleep write in the same cycle
         if (wakeup) begin
            go_sleep <= 1'b0;
         end else if (wr && wb_adr_i == `SCGC_ADDR_SYS_CTRL && wb_sel_i[0]) begin
            go_sleep <= wb_dat_i[`SCGC_SLEEP_BIT];
         end
      end
   end

   // ==========================================
   // Sub-clock control register; interrupt clears processor demand
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         subclock_control_register <= `SCGC_SUBCLK_RESET;
      end else begin
         for (i = 0; i < 3; i = i + 1) begin
            if (wr && wb_adr_i == `SCGC_ADDR_SUBCLK && wb_sel_i[i]) begin
               subclock_control_register[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
            end
         end
         // Hardware clear wins over a software write
         if (irq_pending) begin
            subclock_control_register[2*`SCGC_D_CPU+1] <= 1'b0;
         end
      end
   end

   // ==========================================
   // Pin synchronisers: three stages, change counted when last two agree
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wake_sync <= 3'h0;
         src_sync <= 3'h0;
         src_sel <= 1'b0;
      end else begin
         wake_sync <= {wake_sync[1:0], ext_wakeup};
         src_sync <= {src_sync[1:0], clock_source_select};
         if (src_sync[2] == src_sync[1]) begin
            src_sel <= src_sync[2];
         end
      end
   end

   // ==========================================
   // Source selection and sleep
   // Sleep forces the internal source, so a running external clock stops too
   assign main_clock_select = src_sel | go_sleep;
   // Oscillator off in sleep whichever source is selected
   assign osc_enable = ~go_sleep;
   // Main clock halts in sleep; reset or wake-up restarts it
   assign main_clock_run = ~go_sleep;

   // External devices powered down while asleep
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         external_power_enable <= 1'b1;
      end else begin
         external_power_enable <= ~go_sleep;
      end
   end

   // ==========================================
   // Divider: reference clock and correlator core pulse deletion
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_count <= {DIV_W{1'b0}};
         rf_ref <= 1'b0;
         correlator_core_enable <= 1'b0;
      end else begin
         if (div_count >= div_last(divide_field)) begin
            div_count <= {DIV_W{1'b0}};
         end else begin
            div_count <= div_count + 1'b1;
         end
         // High for the first half of the period; divide by 1 follows below
         rf_ref <= (div_count >= div_last(divide_field)) |
                   (div_count < (div_last(divide_field) >> 1));
         // One pulse kept out of N
         correlator_core_enable <= (div_count >= div_last(divide_field));
      end
   end
   // Divide by 1 passes the main clock itself, otherwise the divided level
   assign rf_reference_clock = (divide_field == `SCGC_DIV_ONE) ? ref_clk : rf_ref;

   // Slow enable: one pulse per 1024 reference periods
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         slow_count <= {SLOW_W{1'b0}};
         slow_enable <= 1'b0;
      end else begin
         slow_enable <= 1'b0;
         if (correlator_core_enable) begin
            slow_count <= slow_count + 1'b1;
            slow_enable <= (slow_count == `SCGC_SLOW_MAX);
         end
      end
   end

   // ==========================================
   // Processor hold: keep clock while a memory access is in flight
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cpu_hold <= 1'b0;
      end else begin
         cpu_hold <= memory_busy;
      end
   end

   // Run decision per domain
   always @* begin
      for (j = 0; j < `SCGC_NUM_DOM; j = j + 1) begin
         // Demand-controlled when both bits set
         next_gate_en[j] = pair_run(subclock_control_register[2*j +: 2], demand_request[j]);
      end
      // Processor runs while an access finishes or an interrupt waits
      next_gate_en[`SCGC_D_CPU] = pair_run(subclock_control_register[2*`SCGC_D_CPU +: 2],
         demand_request[`SCGC_D_CPU] | memory_busy | cpu_hold | irq_pending);
      // Memory controller busy keeps its own clock
      next_gate_en[`SCGC_D_MEMC] = pair_run(subclock_control_register[2*`SCGC_D_MEMC +: 2],
         demand_request[`SCGC_D_MEMC] | memory_busy);
      // Either correlator enable cleared stops both correlator clocks
      if (!subclock_control_register[2*`SCGC_D_CORBUS] ||
          !subclock_control_register[2*`SCGC_D_CORCORE]) begin
         next_gate_en[`SCGC_D_CORBUS] = 1'b0;
         next_gate_en[`SCGC_D_CORCORE] = 1'b0;
      end
      // Serial demands held by the ports themselves through transfers
   end

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         gate_en <= 12'h000;
      end else begin
         gate_en <= next_gate_en;
      end
   end

   // ==========================================
   // Glitch-free gates for each domain
   genvar g;
   generate
      for (g = 0; g < `SCGC_NUM_DOM; g = g + 1) begin : gates
         if (g == `SCGC_D_CORCORE) begin : core
            // Core clock adds pulse deletion to its gate
            scgc_gate u_gate (
               .clk_in(ref_clk),
               .reset_n(reset_n),
               .enable(gate_en[g] & correlator_core_enable),
               .clk_out(subclock[g])
            );
         end else begin : plain
            scgc_gate u_gate (
               .clk_in(ref_clk),
               .reset_n(reset_n),
               .enable(gate_en[g]),
               .clk_out(subclock[g])
            );
         end
      end
   endgenerate
   assign correlator_core_clock = subclock[`SCGC_D_CORCORE];
endmodule

/* scgc_top_chk.sv */
// Port-level assertion checker for the sub-clock gating control
`timescale 1ns/1ps
module scgc_top_chk (
   input wire ref_clk,
   input wire reset_n,
   input wire clock_source_select,
   input wire rtc_wakeup,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   input wire osc_enable,
   input wire main_clock_select,
   input wire main_clock_run,
   input wire external_power_enable,
   input wire correlator_core_clock,
   input wire slow_enable,
   input wire [11:0] subclock
);
   // ==========================================
   // Clocking and sleep relations
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   a_osc_off_sleep: assert property (osc_enable == main_clock_run)
      else $error("oscillator enable disagrees with run state");
   a_sleep_forces_int: assert property (!main_clock_run |-> main_clock_select)
      else $error("sleep without internal source");
   a_power_follows_sleep: assert property ($fell(main_clock_run) |-> ##[0:2] !external_power_enable)
      else $error("power enable still high in sleep");
   // Seven cycles cover the three-stage synchroniser and its agreement check
   a_src_high_int: assert property ((main_clock_run && clock_source_select) [*7] |-> main_clock_select)
      else $error("high select did not pick internal");
   a_src_low_ext: assert property ((main_clock_run && !clock_source_select) [*7] |-> !main_clock_select)
      else $error("low select did not pick external");
   a_rtc_wake_up: assert property (rtc_wakeup |-> ##[1:3] main_clock_run)
      else $error("alarm did not restart the clock");
   a_core_is_gated: assert property (correlator_core_clock == subclock[2])
      else $error("core clock differs from its gate");
   a_slow_single_pulse: assert property (slow_enable |=> !slow_enable)
      else $error("slow enable longer than one cycle");
   // ==========================================
   // Register bus handshake
   a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not one cycle after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
endmodule
bind scgc_top scgc_top_chk i_scgc_top_chk (.ref_clk(ref_clk), .reset_n(reset_n),
   .clock_source_select(clock_source_select), .rtc_wakeup(rtc_wakeup), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .osc_enable(osc_enable), .main_clock_select(main_clock_select),
   .main_clock_run(main_clock_run), .external_power_enable(external_power_enable),
   .correlator_core_clock(correlator_core_clock), .slow_enable(slow_enable), .subclock(subclock));

/* scgc_periph_model.sv */
// Behavioural model of the peripherals and CPU that request sub-clocks
`timescale 1ns/1ps
module scgc_periph_model (
   input wire ref_clk,
   input wire reset_n,
   input wire tx_start,
   input wire rx_start,
   input wire mem_go,
   input wire cor_act,
   output wire [11:0] demand_request,
   output wire memory_busy
);
   // ==========================================
   // Activity timers
   reg [4:0] ser_cnt; // Serial frame cycles left
   reg [4:0] mem_cnt; // Memory access cycles left
   // Demand is dropped only when the frame or access is over
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ser_cnt <= 5'h00;
         mem_cnt <= 5'h00;
      end else begin
         if (tx_start || rx_start) begin
            ser_cnt <= 5'h10;
         end else if (ser_cnt != 5'h00) begin
            ser_cnt <= ser_cnt - 5'h01;
         end
         if (mem_go) begin
            mem_cnt <= 5'h0C;
         end else if (mem_cnt != 5'h00) begin
            mem_cnt <= mem_cnt - 5'h01;
         end
      end
   end
   assign memory_busy = (mem_cnt != 5'h00);
   // Always-on domains hold demand high; the timer never asks
   assign demand_request = {1'b1, 1'b0, memory_busy, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0,
      ser_cnt != 5'h00, cor_act, cor_act, 1'b1};
endmodule

/* scgc_top_bench.sv */
// Self-checking bench for the sub-clock gating control
`timescale 1ns/1ps
`include "scgc_regs.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; $display("[FAIL] %0t mismatch", $time); end end
module scgc_top_bench;
   logic ref_clk = 0, reset_n = 0, src = 0, ext_wk = 0, rtc_wk = 0, irq = 0;
   logic req = 0, we = 0, tx = 0, rx = 0, mg = 0, ca = 0, s, p;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rd;
   wire [31:0] dat_o;
   wire ack, osc_en, msel, run, epwr, rfc, cen, ccl, slow, mbusy;
   wire [11:0] sub, dmd;
   int n_fail = 0, total_checks = 0, cnt, rc;
   // ==========================================
   // Clock, design and far side
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   scgc_top i_scgc_top (.ref_clk(ref_clk), .reset_n(reset_n), .ext_clock(1'b0), .osc_clock(1'b0),
      .clock_source_select(src), .ext_wakeup(ext_wk), .rtc_wakeup(rtc_wk), .demand_request(dmd),
      .memory_busy(mbusy), .irq_pending(irq), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .osc_enable(osc_en), .main_clock_select(msel), .main_clock_run(run),
      .external_power_enable(epwr), .rf_reference_clock(rfc), .correlator_core_enable(cen),
      .correlator_core_clock(ccl), .slow_enable(slow), .subclock(sub));
   scgc_periph_model i_scgc_periph_model (.ref_clk(ref_clk), .reset_n(reset_n), .tx_start(tx),
      .rx_start(rx), .mem_go(mg), .cor_act(ca), .demand_request(dmd), .memory_busy(mbusy));
   // ==========================================
   // Tasks
   task automatic wrap_up;
      $display("checks %0d fails %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Classic cycle; the request is held until ack is seen at an edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge ref_clk);
      req <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      for (k = 0; k < 20 && ack !== 1'b1; k++) @(posedge ref_clk);
      rd = dat_o;
      if (k == 20) begin
         n_fail++;
         wrap_up();
      end
      req <= 0;
      we <= 0;
   endtask
   // Looks at a gated clock inside its high phase
   task automatic gate(input int i, input logic e);
      repeat (4) @(posedge ref_clk);
      #2;
      `CHK(sub[i], e)
   endtask
   // Hang guard
   initial begin
      repeat (50000) @(posedge ref_clk);
      n_fail++;
      wrap_up();
   end
   // ==========================================
   // Main sequence
   initial begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1;
      wb(0, `SCGC_ADDR_SYS_CTRL, 0);
      `CHK(rd[3:0], 4'h7)
      wb(0, `SCGC_ADDR_SUBCLK, 0);
      `CHK(rd[23:0], `SCGC_SUBCLK_RESET)
      gate(4, 1'b1);
      wb(1, 8'hF4, 32'hFFFFFFFF);
      wb(0, 8'hF4, 0);
      `CHK(rd, 32'h0)
      wb(0, `SCGC_ADDR_SYS_CTRL, 0);
      `CHK(rd[3:0], 4'h7)
      `CHK(msel, 1'b0)
      src <= 1;
      repeat (8) @(posedge ref_clk);
      `CHK(msel, 1'b1)
      wb(0, `SCGC_ADDR_STATUS, 0);
      `CHK(rd[12], 1'b1)
      src <= 0;
      // Every divide code: eight periods hold eight pulses and eight rises
      for (int f = 0; f < 8; f++) begin
         wb(1, `SCGC_ADDR_SYS_CTRL, 32'(f));
         repeat (20) @(posedge ref_clk);
         // Start on a low phase so the window spans whole periods at divide by 1
         @(negedge ref_clk);
         #2 p = rfc;
         cnt = 0;
         rc = 0;
         repeat (8 * (f + 1)) begin
            @(posedge ref_clk);
            if (cen === 1'b1) cnt++;
            #2 s = rfc;
            if (s && !p) rc++;
            p = s;
            @(negedge ref_clk);
            #2 s = rfc;
            if (s && !p) rc++;
            p = s;
         end
         `CHK(cnt, 8)
         `CHK(rc, 8)
      end
      wb(1, `SCGC_ADDR_SYS_CTRL, 0);
      for (rc = 0; rc < 1200 && slow !== 1'b1; rc++) @(posedge ref_clk);
      if (rc == 1200) begin n_fail++; wrap_up(); end
      @(posedge ref_clk);
      for (cnt = 1; cnt < 1200 && slow !== 1'b1; cnt++) @(posedge ref_clk);
      if (cnt == 1200) begin n_fail++; wrap_up(); end
      `CHK(cnt, `SCGC_SLOW_FACTOR)
      // Sleep, then wake by alarm and by the pin
      for (int w = 0; w < 2; w++) begin
         wb(1, `SCGC_ADDR_SYS_CTRL, 32'h8);
         repeat (3) @(posedge ref_clk);
         `CHK({run, osc_en, msel, epwr}, 4'b0010)
         rtc_wk <= (w == 0);
         ext_wk <= (w == 1);
         for (rc = 0; rc < 50 && run !== 1'b1; rc++) @(posedge ref_clk);
         if (rc == 50) begin n_fail++; wrap_up(); end
         rtc_wk <= 0;
         ext_wk <= 0;
         repeat (3) @(posedge ref_clk);
         `CHK({run, osc_en, epwr}, 3'b111)
      end
      // Serial port one on demand
      wb(1, `SCGC_ADDR_SUBCLK, 32'h5555D5);
      gate(3, 1'b0);
      tx <= 1;
      @(posedge ref_clk);
      tx <= 0;
      gate(3, 1'b1);
      repeat (20) @(posedge ref_clk);
      gate(3, 1'b0);
      rx <= 1;
      @(posedge ref_clk);
      rx <= 0;
      gate(3, 1'b1);
      wb(1, `SCGC_ADDR_SUBCLK, 32'h555515);
      gate(3, 1'b0);
      // Correlator pair
      ca <= 1;
      wb(1, `SCGC_ADDR_SUBCLK, 32'h55557D);
      gate(1, 1'b1);
      gate(2, 1'b1);
      `CHK(ccl, 1'b1)
      ca <= 0;
      gate(2, 1'b0);
      `CHK(ccl, 1'b0)
      ca <= 1;
      wb(1, `SCGC_ADDR_SUBCLK, 32'h555579);
      gate(2, 1'b0);
      gate(1, 1'b0);
      // Processor halt and interrupt restart
      mg <= 1;
      @(posedge ref_clk);
      mg <= 0;
      wb(1, `SCGC_ADDR_SUBCLK, 32'h755555);
      gate(10, 1'b1);
      repeat (12) @(posedge ref_clk);
      gate(10, 1'b0);
      irq <= 1;
      gate(10, 1'b1);
      wb(0, `SCGC_ADDR_SUBCLK, 0);
      `CHK(rd[21], 1'b0)
      irq <= 0;
      wrap_up();
   end
endmodule
